/* File: rtl/dds_source_pkg.sv */
/*
 * Shared constants for the synthesizer source-priority core: register
 * indices and byte addresses, control field positions, reset values,
 * pacing counts and the source encoding.
 * Assumes a single 100 MHz sample clock and a word-wide register port.
 */
package dds_source_pkg;

    // printed indices are not all word aligned, so byte address = 4 * index
    localparam logic [7:0] IDX_CTRL_MAIN = 8'h00;
    localparam logic [7:0] IDX_CTRL_MODE = 8'h01;
    localparam logic [7:0] IDX_MOD_FREQ = 8'h04;
    localparam logic [7:0] IDX_MOD_DEN = 8'h05;
    localparam logic [7:0] IDX_MOD_NUM = 8'h06;
    localparam logic [7:0] IDX_STATUS = 8'h07;
    localparam logic [7:0] IDX_PROF_FREQ = 8'h10;
    localparam logic [7:0] IDX_PROF_PHAMP = 8'h18;
    localparam logic [7:0] ADDR_CTRL_MAIN = 8'(IDX_CTRL_MAIN * 4);
    localparam logic [7:0] ADDR_CTRL_MODE = 8'(IDX_CTRL_MODE * 4);
    localparam logic [7:0] ADDR_MOD_FREQ = 8'(IDX_MOD_FREQ * 4);
    localparam logic [7:0] ADDR_MOD_DEN = 8'(IDX_MOD_DEN * 4);
    localparam logic [7:0] ADDR_MOD_NUM = 8'(IDX_MOD_NUM * 4);
    localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
    localparam logic [7:0] ADDR_PROF_FREQ = 8'(IDX_PROF_FREQ * 4);
    localparam logic [7:0] ADDR_PROF_PHAMP = 8'(IDX_PROF_PHAMP * 4);

    // control fields
    localparam int BIT_KEYING_EN = 8;
    localparam int BIT_SINE_EN = 16;
    localparam int LSB_PAR_DEST = 16;
    localparam int BIT_MODULUS_EN = 18;
    localparam int BIT_RAMP_EN = 19;
    localparam int LSB_RAMP_DEST = 20;
    localparam int BIT_PARALLEL_EN = 22;
    localparam int BIT_PROFILE_EN = 23;
    localparam int LSB_PROF_AMP = 16;

    localparam logic [31:0] RESET_CTRL_MAIN = 32'h0000_0000;
    localparam logic [31:0] RESET_CTRL_MODE = 32'h0000_0000;
    localparam logic [31:0] RESET_MOD_DEN = 32'h0000_0002;

    // destination codes for ramp and parallel data
    localparam logic [1:0] DEST_FREQ = 2'h0;
    localparam logic [1:0] DEST_PHASE = 2'h1;
    localparam logic [1:0] DEST_AMP = 2'h2;
    localparam logic [1:0] DEST_POLAR = 2'h3;

    // modulation pacing: one update per sixteen sample clocks
    localparam int PACE_DIV = 16;
    localparam logic [3:0] PACE_TICK = 4'(PACE_DIV / 2 - 1);
    localparam logic [12:0] AMP_FULL = 13'h1000;

    typedef enum logic [2:0]
    {
        SRC_PROFILE = 3'b000,
        SRC_RAMP = 3'b001,
        SRC_PARALLEL = 3'b010,
        SRC_MODULUS = 3'b011,
        SRC_KEYING = 3'b100,
        SRC_FIXED = 3'b101
    } src_e;

endpackage

/* File: rtl/dds_phase_to_amp.sv */
/*
 * Phase to amplitude converter: quarter-wave table with mirroring,
 * sine or cosine selectable, one registered cycle of latency.
 * Assumes the caller has already added the phase offset.
 */
module dds_phase_to_amp
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [15:0] phase_in,
    input wire logic sine_in,
    output logic signed [11:0] sample_out
);

    logic [15:0] angle;
    logic [3:0] index;
    logic [10:0] magnitude;
    logic signed [11:0] next_sample;

    // coarse table; 64 points per turn trades purity for area
    function automatic logic [10:0] quarter(input logic [3:0] i);
        logic [10:0] v;
        v = 11'h000;
        unique case (i)
            4'h0: v = 11'h064;
            4'h1: v = 11'h12C;
            4'h2: v = 11'h1F1;
            4'h3: v = 11'h2B2;
            4'h4: v = 11'h36B;
            4'h5: v = 11'h41C;
            4'h6: v = 11'h4C3;
            4'h7: v = 11'h55F;
            4'h8: v = 11'h5ED;
            4'h9: v = 11'h66C;
            4'hA: v = 11'h6DC;
            4'hB: v = 11'h73B;
            4'hC: v = 11'h787;
            4'hD: v = 11'h7C2;
            4'hE: v = 11'h7E9;
            4'hF: v = 11'h7FD;
        endcase
        return v;
    endfunction

    // cosine is sine advanced by a quarter turn
    always_comb
    begin
        angle = sine_in ? phase_in : phase_in + 16'h4000;
        index = angle[14] ? ~angle[13:10] : angle[13:10];
        magnitude = quarter(index);
        next_sample = angle[15] ? -$signed({1'b0, magnitude}) : $signed({1'b0, magnitude});
    end

    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
            sample_out <= 12'sh000;
        else
            sample_out <= next_sample;
    end

endmodule

/* File: rtl/dds_source_core.sv */
/*
 * Synthesizer core with data-source priority for frequency, phase and
 * amplitude, a programmable-modulus phase accumulator, the parallel data
 * clock and the sample path to the converter.
 * Assumes ramp, keying ramp and parallel data are synchronous to clock_in
 * and that software drives the register port one strobe at a time.
 */
// The implementer's own choices: the register addresses and strobed register access.
module dds_source_core
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] address_in,
    input wire logic [31:0] write_data_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [31:0] read_data_out,
    input wire logic [2:0] profile_select_inputs_in,
    input wire logic [31:0] ramp_generator_in,
    input wire logic output_amplitude_keying_active_in,
    input wire logic [11:0] output_amplitude_keying_in,
    input wire logic [31:0] parallel_data_in,
    output logic parallel_clock_out,
    output logic signed [11:0] sample_out
);

    logic [31:0] ctrl_main;
    logic [31:0] ctrl_mode;
    logic [31:0] mod_freq;
    logic [31:0] mod_den;
    logic [31:0] mod_num;
    logic [31:0] profile_freq [8];
    logic [27:0] profile_phamp [8];
    logic [31:0] next_ctrl_main;
    logic [31:0] next_ctrl_mode;
    logic [31:0] next_mod_freq;
    logic [31:0] next_mod_den;
    logic [31:0] next_mod_num;
    logic [31:0] next_profile_freq [8];
    logic [27:0] next_profile_phamp [8];
    logic [31:0] next_read_data;

    logic sine_en;
    logic keying_en;
    logic profile_en;
    logic parallel_en;
    logic modulus_en;
    logic ramp_en;
    logic [1:0] ramp_dest;
    logic [1:0] par_dest;

    assign sine_en = ctrl_main[dds_source_pkg::BIT_SINE_EN];
    assign keying_en = ctrl_main[dds_source_pkg::BIT_KEYING_EN];
    assign profile_en = ctrl_mode[dds_source_pkg::BIT_PROFILE_EN];
    assign parallel_en = ctrl_mode[dds_source_pkg::BIT_PARALLEL_EN];
    assign modulus_en = ctrl_mode[dds_source_pkg::BIT_MODULUS_EN];
    assign ramp_en = ctrl_mode[dds_source_pkg::BIT_RAMP_EN];
    assign ramp_dest = ctrl_mode[dds_source_pkg::LSB_RAMP_DEST +: 2];
    assign par_dest = ctrl_mode[dds_source_pkg::LSB_PAR_DEST +: 2];

    logic [3:0] pace_count;
    logic [3:0] next_pace_count;
    logic tick;
    logic [2:0] profile_index;
    logic [2:0] next_profile_index;
    logic [31:0] frequency_tuning_word;
    logic [15:0] phase_offset_word;
    logic [12:0] amplitude_scale_factor;
    logic [31:0] next_frequency_tuning_word;
    logic [15:0] next_phase_offset_word;
    logic [12:0] next_amplitude_scale_factor;
    dds_source_pkg::src_e freq_src;
    dds_source_pkg::src_e phase_src;
    dds_source_pkg::src_e amp_src;
    dds_source_pkg::src_e next_freq_src;
    dds_source_pkg::src_e next_phase_src;
    dds_source_pkg::src_e next_amp_src;

    // a parallel destination covers a parameter when it targets it
    function automatic logic par_claims(input logic en, input logic [1:0] dest,
                                        input logic [1:0] want);
        return en && (dest == want || (dest == dds_source_pkg::DEST_POLAR &&
                                       want != dds_source_pkg::DEST_FREQ));
    endfunction

    // register port: writes land at once, reads answer one cycle later
    always_comb
    begin
        next_ctrl_main = ctrl_main;
        next_ctrl_mode = ctrl_mode;
        next_mod_freq = mod_freq;
        next_mod_den = mod_den;
        next_mod_num = mod_num;
        next_profile_freq = profile_freq;
        next_profile_phamp = profile_phamp;
        next_read_data = 32'h0000_0000;
        if (write_in)
        begin
            unique case (address_in)
                dds_source_pkg::ADDR_CTRL_MAIN: next_ctrl_main = write_data_in;
                dds_source_pkg::ADDR_CTRL_MODE: next_ctrl_mode = write_data_in;
                dds_source_pkg::ADDR_MOD_FREQ: next_mod_freq = write_data_in;
                dds_source_pkg::ADDR_MOD_DEN: next_mod_den = write_data_in;
                dds_source_pkg::ADDR_MOD_NUM: next_mod_num = write_data_in;
                default:
                begin
                    if (address_in[7:5] == dds_source_pkg::ADDR_PROF_FREQ[7:5])
                        next_profile_freq[address_in[4:2]] = write_data_in;
                    else if (address_in[7:5] == dds_source_pkg::ADDR_PROF_PHAMP[7:5])
                        next_profile_phamp[address_in[4:2]] = write_data_in[27:0];
                end
            endcase
        end
        if (read_in)
        begin
            unique case (address_in)
                dds_source_pkg::ADDR_CTRL_MAIN: next_read_data = ctrl_main;
                dds_source_pkg::ADDR_CTRL_MODE: next_read_data = ctrl_mode;
                dds_source_pkg::ADDR_MOD_FREQ: next_read_data = mod_freq;
                dds_source_pkg::ADDR_MOD_DEN: next_read_data = mod_den;
                dds_source_pkg::ADDR_MOD_NUM: next_read_data = mod_num;
                dds_source_pkg::ADDR_STATUS: next_read_data = {20'h00000, profile_index,
                                                amp_src, phase_src, freq_src};
                default:
                begin
                    if (address_in[7:5] == dds_source_pkg::ADDR_PROF_FREQ[7:5])
                        next_read_data = profile_freq[address_in[4:2]];
                    else if (address_in[7:5] == dds_source_pkg::ADDR_PROF_PHAMP[7:5])
                        next_read_data = {4'h0, profile_phamp[address_in[4:2]]};
                end
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_main <= dds_source_pkg::RESET_CTRL_MAIN;
            ctrl_mode <= dds_source_pkg::RESET_CTRL_MODE;
            mod_freq <= 32'h0000_0000;
            mod_den <= dds_source_pkg::RESET_MOD_DEN;
            mod_num <= 32'h0000_0000;
            profile_freq <= '{default: 32'h0000_0000};
            profile_phamp <= '{default: 28'h000_0000};
            read_data_out <= 32'h0000_0000;
        end
        else
        begin
            ctrl_main <= next_ctrl_main;
            ctrl_mode <= next_ctrl_mode;
            mod_freq <= next_mod_freq;
            mod_den <= next_mod_den;
            mod_num <= next_mod_num;
            profile_freq <= next_profile_freq;
            profile_phamp <= next_profile_phamp;
            read_data_out <= next_read_data;
        end
    end

    // source selection, taken only at the data clock rising edge
    always_comb
    begin
        logic [31:0] pf;
        logic [15:0] pp;
        logic [11:0] pa;
        pf = profile_freq[profile_select_inputs_in];
        pp = profile_phamp[profile_select_inputs_in][15:0];
        pa = profile_phamp[profile_select_inputs_in][dds_source_pkg::LSB_PROF_AMP +: 12];
        next_pace_count = pace_count + 4'h1;
        next_profile_index = profile_index;
        next_frequency_tuning_word = frequency_tuning_word;
        next_phase_offset_word = phase_offset_word;
        next_amplitude_scale_factor = amplitude_scale_factor;
        next_freq_src = freq_src;
        next_phase_src = phase_src;
        next_amp_src = amp_src;
        if (tick)
        begin
            next_profile_index = profile_select_inputs_in;
            // frequency: modulus, ramp, profile, parallel, fallback profile
            if (modulus_en)
            begin
                next_freq_src = dds_source_pkg::SRC_MODULUS;
                next_frequency_tuning_word = mod_freq;
            end
            else if (ramp_en && ramp_dest == dds_source_pkg::DEST_FREQ)
            begin
                next_freq_src = dds_source_pkg::SRC_RAMP;
                next_frequency_tuning_word = ramp_generator_in;
            end
            else if (profile_en || !par_claims(parallel_en, par_dest,
                                               dds_source_pkg::DEST_FREQ))
            begin
                next_freq_src = dds_source_pkg::SRC_PROFILE;
                next_frequency_tuning_word = pf;
            end
            else
            begin
                next_freq_src = dds_source_pkg::SRC_PARALLEL;
                next_frequency_tuning_word = parallel_data_in;
            end
            // phase: ramp is not available while modulus mode is enabled
            if (!modulus_en && ramp_en && ramp_dest == dds_source_pkg::DEST_PHASE)
            begin
                next_phase_src = dds_source_pkg::SRC_RAMP;
                next_phase_offset_word = ramp_generator_in[31:16];
            end
            else if (modulus_en || profile_en ||
                     !par_claims(parallel_en, par_dest, dds_source_pkg::DEST_PHASE))
            begin
                next_phase_src = dds_source_pkg::SRC_PROFILE;
                next_phase_offset_word = pp;
            end
            else
            begin
                next_phase_src = dds_source_pkg::SRC_PARALLEL;
                next_phase_offset_word = parallel_data_in[31:16];
            end
            // amplitude: keying ramp first, all scaling gated by keying enable
            if (!keying_en)
            begin
                next_amp_src = dds_source_pkg::SRC_FIXED;
                next_amplitude_scale_factor = dds_source_pkg::AMP_FULL;
            end
            else if (output_amplitude_keying_active_in)
            begin
                next_amp_src = dds_source_pkg::SRC_KEYING;
                next_amplitude_scale_factor = {1'b0, output_amplitude_keying_in};
            end
            else if (!modulus_en && ramp_en && ramp_dest == dds_source_pkg::DEST_AMP)
            begin
                next_amp_src = dds_source_pkg::SRC_RAMP;
                next_amplitude_scale_factor = {1'b0, ramp_generator_in[31:20]};
            end
            else if (modulus_en || profile_en ||
                     !par_claims(parallel_en, par_dest, dds_source_pkg::DEST_AMP))
            begin
                next_amp_src = dds_source_pkg::SRC_PROFILE;
                next_amplitude_scale_factor = {1'b0, pa};
            end
            else
            begin
                next_amp_src = dds_source_pkg::SRC_PARALLEL;
                next_amplitude_scale_factor = {1'b0, parallel_data_in[11:0]};
            end
        end
    end

    assign tick = pace_count == dds_source_pkg::PACE_TICK;

    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            pace_count <= 4'h0;
            parallel_clock_out <= 1'b0;
            profile_index <= 3'h0;
            frequency_tuning_word <= 32'h0000_0000;
            phase_offset_word <= 16'h0000;
            amplitude_scale_factor <= dds_source_pkg::AMP_FULL;
            freq_src <= dds_source_pkg::SRC_PROFILE;
            phase_src <= dds_source_pkg::SRC_PROFILE;
            amp_src <= dds_source_pkg::SRC_FIXED;
        end
        else
        begin
            pace_count <= next_pace_count;
            parallel_clock_out <= next_pace_count[3];
            profile_index <= next_profile_index;
            frequency_tuning_word <= next_frequency_tuning_word;
            phase_offset_word <= next_phase_offset_word;
            amplitude_scale_factor <= next_amplitude_scale_factor;
            freq_src <= next_freq_src;
            phase_src <= next_phase_src;
            amp_src <= next_amp_src;
        end
    end

    // phase accumulator plus auxiliary modulus accumulator
    logic [31:0] phase_acc;
    logic [31:0] aux_acc;
    logic [31:0] next_phase_acc;
    logic [31:0] next_aux_acc;
    logic [32:0] aux_sum;
    logic carry;

    always_comb
    begin
        aux_sum = {1'b0, aux_acc} + {1'b0, mod_num};
        carry = modulus_en && aux_sum >= {1'b0, mod_den};
        next_aux_acc = 32'h0000_0000;
        if (modulus_en)
            next_aux_acc = carry ? 32'(aux_sum - {1'b0, mod_den}) : aux_sum[31:0];
        // wraps modulo 2^32, so upper-half words alias with no special case
        next_phase_acc = phase_acc + frequency_tuning_word + {31'h0, carry};
    end

    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            phase_acc <= 32'h0000_0000;
            aux_acc <= 32'h0000_0000;
        end
        else
        begin
            phase_acc <= next_phase_acc;
            aux_acc <= next_aux_acc;
        end
    end

    // offset, convert, then scale
    logic [15:0] conv_phase;
    logic signed [11:0] raw_sample;
    logic signed [25:0] product;
    logic signed [11:0] next_sample;

    assign conv_phase = phase_acc[31:16] + phase_offset_word;

    dds_phase_to_amp phase_to_amp
    (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .phase_in(conv_phase),
        .sine_in(sine_en),
        .sample_out(raw_sample)
    );

    always_comb
    begin
        product = raw_sample * $signed({1'b0, amplitude_scale_factor});
        next_sample = product[23:12];
    end

    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
            sample_out <= 12'sh000;
        else
            sample_out <= next_sample;
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    chk_param_pace: assert property ($changed(frequency_tuning_word) |-> $past(tick))
        else $error("frequency word changed off the data clock edge");
    // data clock: eight cycles high then eight low, so no early rise
    chk_clock_period: assert property ($rose(parallel_clock_out) |->
        parallel_clock_out [*8] ##1 !parallel_clock_out [*8])
        else $error("data clock rose early");
    chk_clock_rate: assert property ($rose(parallel_clock_out) |->
        ##16 $rose(parallel_clock_out))
        else $error("data clock not one sixteenth rate");
    chk_modulus_freq: assert property (tick && modulus_en |=>
        freq_src == dds_source_pkg::SRC_MODULUS && frequency_tuning_word == $past(mod_freq))
        else $error("modulus mode lost frequency");
    chk_modulus_noramp: assert property (modulus_en && tick |=>
        phase_src != dds_source_pkg::SRC_RAMP && amp_src != dds_source_pkg::SRC_RAMP)
        else $error("ramp swept in modulus mode");
    chk_modulus_phase: assert property (modulus_en && tick |=>
        phase_src == dds_source_pkg::SRC_PROFILE)
        else $error("modulus phase not from profile");
    chk_keying_gate: assert property (tick && !keying_en |=>
        amplitude_scale_factor == dds_source_pkg::AMP_FULL)
        else $error("amplitude scaled without keying enable");
    chk_keying_wins: assert property (tick && keying_en &&
        output_amplitude_keying_active_in |=> amp_src == dds_source_pkg::SRC_KEYING)
        else $error("keying ramp did not win amplitude");
    chk_profile_freq: assert property (tick && !modulus_en && profile_en &&
        !(ramp_en && ramp_dest == dds_source_pkg::DEST_FREQ) |=>
        freq_src == dds_source_pkg::SRC_PROFILE)
        else $error("profile lost frequency to lower source");
    // checked where sources load: enables may change between ticks
    chk_parallel_last: assert property (tick && (profile_en || modulus_en) |=>
        freq_src != dds_source_pkg::SRC_PARALLEL &&
        phase_src != dds_source_pkg::SRC_PARALLEL &&
        amp_src != dds_source_pkg::SRC_PARALLEL)
        else $error("parallel port drove claimed parameter");
    chk_accum_step: assert property (!modulus_en && !$past(modulus_en) |=>
        phase_acc == 32'($past(phase_acc) + $past(frequency_tuning_word)))
        else $error("accumulator step wrong");
    chk_select_capture: assert property (tick |=>
        profile_index == $past(profile_select_inputs_in))
        else $error("profile select not captured");
    chk_ramp_phase: assert property (tick && !modulus_en && ramp_en &&
        ramp_dest == dds_source_pkg::DEST_PHASE |=>
        {phase_offset_word, 16'h0000} == ($past(ramp_generator_in) & 32'hFFFF_0000))
        else $error("ramp phase not its upper bits");

    cov_modulus: cover property (modulus_en && carry);
    cov_ramp_freq: cover property (tick ##1 freq_src == dds_source_pkg::SRC_RAMP);
    cov_parallel_polar: cover property (phase_src == dds_source_pkg::SRC_PARALLEL &&
        amp_src == dds_source_pkg::SRC_PARALLEL);
    cov_keying: cover property (amp_src == dds_source_pkg::SRC_KEYING);

endmodule

/* File: bench/dds_mod_source.sv */
/*
 * far-side modulation sources: ramp, keying ramp, parallel word, profile
 * select. assumes the core's data clock paces every update.
 */
module dds_mod_source
(
    input wire logic clock_in,
    input wire logic parallel_clock_in,
    output logic [2:0] profile_select_out = 3'h0,
    output logic [31:0] ramp_out = 32'h0,
    output logic keying_active_out = 1'b0,
    output logic [11:0] keying_out = 12'h0,
    output logic [31:0] parallel_data_out = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] state = 32'hAE87199E;
    logic last_clock = 1'b0;
    // change one cycle after a data clock rise so setup to the next tick is long
    always @(posedge clock_in)
    begin
        last_clock <= parallel_clock_in;
        if (parallel_clock_in && !last_clock)
        begin
            state = state ^ (state << 13);
            state = state ^ (state >> 17);
            state = state ^ (state << 5);
            profile_select_out <= state[2:0];
            keying_active_out <= state[3];
            keying_out <= state[15:4];
            ramp_out <= state;
            parallel_data_out <= ~state;
        end
    end
endmodule

/* File: bench/dds_core_source_priority_tb_top.sv */
/*
 * self-checking bench: register port, source priority via status, data clock.
 * assumes the core reads status one cycle after the read strobe.
 */
module dds_core_source_priority_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0, reset_n_in = 1'b0, write_in = 1'b0, read_in = 1'b0;
    logic [7:0] address_in = 8'h00;
    logic [31:0] write_data_in = 32'h0, read_data_out, ramp, par, r, d, w;
    logic pclk, kact, ken, ka;
    logic [2:0] ps, sel;
    logic [11:0] kamp;
    logic [8:0] e;
    logic signed [11:0] sample_out, s0;
    int bad_count = 0, checks_done = 0;
    initial forever #5 clock_in = ~clock_in;
    dds_mod_source far (.clock_in(clock_in), .parallel_clock_in(pclk),
        .profile_select_out(ps), .ramp_out(ramp), .keying_active_out(kact),
        .keying_out(kamp), .parallel_data_out(par));
    dds_source_core DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .address_in(address_in), .write_data_in(write_data_in), .write_in(write_in),
        .read_in(read_in), .read_data_out(read_data_out), .profile_select_inputs_in(ps),
        .ramp_generator_in(ramp), .output_amplitude_keying_active_in(kact),
        .output_amplitude_keying_in(kamp), .parallel_data_in(par),
        .parallel_clock_out(pclk), .sample_out(sample_out));
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // expected {amp, phase, freq} source codes, modulus first (amp: keying gate and keying ramp before it), parallel last
    function automatic logic [8:0] exp_src(logic [31:0] v, logic k, logic a);
        logic [2:0] f, p, m;
        logic [1:0] dst;
        dst = 2'(v[5:4] % 3);
        f = v[0] ? 3'h3 : (v[1] && dst == 0) ? 3'h1 : v[3] ? 3'h0 :
            (v[2] && v[7:6] == 0) ? 3'h2 : 3'h0;
        p = v[0] ? 3'h0 : (v[1] && dst == 1) ? 3'h1 : v[3] ? 3'h0 :
            (v[2] && v[6]) ? 3'h2 : 3'h0;
        m = !k ? 3'h5 : a ? 3'h4 : v[0] ? 3'h0 : (v[1] && dst == 2) ? 3'h1 : v[3] ? 3'h0 :
            (v[2] && v[7]) ? 3'h2 : 3'h0;
        return {m, p, f};
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        address_in <= a;
        write_data_in <= v;
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
        // idle edge, so a following call never drives the strobe twice in one step
        @(posedge clock_in);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        address_in <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1 v = read_data_out;
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        repeat (4) @(posedge clock_in);
        #1;
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #300000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        rd(dds_source_pkg::ADDR_MOD_DEN, d);
        check("modulus denominator", d, dds_source_pkg::RESET_MOD_DEN);
        rd(8'hFC, d);
        check("unmapped read", d, 32'h0);
        // data clock: high 8 cycles, low 8, period 16
        @(posedge pclk);
        repeat (8) @(posedge clock_in);
        #1 check("data clock low", pclk, 1'b0);
        repeat (7) @(posedge clock_in);
        #1 check("data clock still low", pclk, 1'b0);
        @(posedge clock_in);
        #1 check("data clock high", pclk, 1'b1);
        // cosine at phase 0 must equal sine at a quarter turn
        for (int i = 0; i < 8; i++)
            wr(8'(dds_source_pkg::ADDR_PROF_PHAMP + 4 * i), 32'h0);
        settle();
        s0 = sample_out;
        check("cosine peak", 32'(s0), 32'(12'sh7FD));
        for (int i = 0; i < 8; i++)
            wr(8'(dds_source_pkg::ADDR_PROF_PHAMP + 4 * i), 32'h4000);
        wr(dds_source_pkg::ADDR_CTRL_MAIN, 32'h0001_0000);
        settle();
        check("sine quarter turn", 32'(sample_out), 32'(s0));
        r = 32'hAE87199E;
        // host keeps every programmed frequency word in the lower half
        for (int i = 0; i < 8; i++)
        begin
            r = xs(r);
            wr(8'(dds_source_pkg::ADDR_PROF_FREQ + 4 * i), {1'b0, r[30:0]});
        end
        rd(8'(dds_source_pkg::ADDR_PROF_FREQ + 28), d);
        check("profile word", d, {1'b0, r[30:0]});
        wr(dds_source_pkg::ADDR_MOD_NUM, 32'h0000_0003);
        wr(dds_source_pkg::ADDR_MOD_DEN, 32'h0000_0007);
        wr(dds_source_pkg::ADDR_MOD_FREQ, 32'h0CCC_CCCC);
        rd(dds_source_pkg::ADDR_MOD_NUM, d);
        check("modulus numerator", d, 32'h0000_0003);
        for (int i = 0; i < 40; i++)
        begin
            r = (i == 0) ? 32'h0000_000C : xs(r);
            ken = r[8];
            wr(dds_source_pkg::ADDR_CTRL_MAIN, {15'h0, r[9], 7'h0, ken, 8'h00});
            w = {8'h00, r[3], r[2], 2'(r[5:4] % 3), r[1], r[0], r[7:6], 16'h0000};
            wr(dds_source_pkg::ADDR_CTRL_MODE, w);
            rd(dds_source_pkg::ADDR_CTRL_MODE, d);
            check("mode readback", d, w);
            @(posedge clock_in);
            @(posedge pclk);
            // take what the core sampled at this tick; the far side moves next cycle
            sel = ps;
            ka = kact;
            e = exp_src(r, ken, ka);
            rd(dds_source_pkg::ADDR_STATUS, d);
            check("frequency source", d[2:0], e[2:0]);
            check("phase source", d[5:3], e[5:3]);
            check("amplitude source", d[8:6], e[8:6]);
            check("profile index", d[11:9], sel);
        end
        print_verdict();
    end
endmodule
